// file: design/lsl_unit_regs.vh
// Register offsets, field positions, reset values and opcode patterns of the left-shift unit
`ifndef LSL_UNIT_REGS_VH
`define LSL_UNIT_REGS_VH

// Word offsets on the register bus (byte addresses)
`define OFS_ACC          8'h00
`define OFS_PROD         8'h04
`define OFS_MCAND        8'h08
`define OFS_STATUS       8'h0C
`define OFS_RPT          8'h10
`define OFS_OPCODE       8'h14

// Status register field positions
`define ST_CARRY         0
`define ST_NEG           1
`define ST_ZERO          2
`define ST_OBJECT_MODE_BIT       3
`define ST_ILLEGAL       4
`define ST_DONE          5
`define ST_WIDTH         6

// Reset values
`define RST_ACC          32'h00000000
`define RST_PROD         32'h00000000
`define RST_MCAND        32'h00000000
`define RST_STATUS       6'h00
`define RST_RPT          16'h0000
`define RST_OPCODE       16'h0000

// Opcode patterns
`define OPC_HALF_IMM     11'h7FC
`define OPC_HALF_REG     15'h7FB3
`define OPC_ACC_REG      16'hFF50
`define OPC_WIDE_IMM     12'h56A
`define OPC_WIDE_REG     16'h5652

// Count widths taken from the multiplicand-high word
`define CNT4_BITS        4
`define CNT6_BITS        6

`endif

// file: design/logical_shift_left_unit.v
// Logical left-shift datapath with its accumulator, product, multiplicand and flags behind Wishbone
//
// The Wishbone register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "lsl_unit_regs.vh"

// What this block does
// RULE1: Accumulator shift by register uses only the low four count bits, 0 to 15.
// RULE2: Vacated low bits of the 32-bit accumulator fill with zeros.
// RULE3: Accumulator register shift clears carry on zero count, else last bit out.
// RULE4: Zero flag follows the 32-bit result, also for a zero count.
// RULE5: Negative flag follows result bit 31, also for a zero count.
// RULE6: Shifts are not repeatable; a pending repeat count is cleared, one execution.
// RULE7: Half immediate shift decoded by pattern, A selects half, amount 1 to 16.
// RULE8: Half immediate shift zero-fills the half and keeps last bit out in carry.
// RULE9: Half shifts set negative from bit 15 of the selected half result.
// RULE10: Half shifts set zero when the selected 16-bit result is zero.
// RULE11: Half register shift decoded in one cycle, A selects, count low four bits.
// RULE12: Half register shift clears carry on zero count, else last bit out.
// RULE13: Half register shift updates negative and zero even for a zero count.
// RULE14: Wide immediate shift needs object mode 1, shifts pair 1 to 16, zero-fill.
// RULE15: Wide shifts take negative from bit 31 of the accumulator part.
// RULE16: Wide shifts set zero only when all 64 result bits are zero.
// RULE17: Wide immediate shift loads carry with the last bit out of 64 bits.
// RULE18: Wide register shift decoded from its fixed opcode, object mode 1, one cycle.
// RULE19: Shift count comes from the upper 16 bits of the multiplicand register.
// RULE20: Wide register shift uses six count bits; zero count clears carry.
// RULE21: Accumulator register shift decoded from fixed opcode in either object mode.
// RULE22: Anything a shift does not write keeps its previous value.
module logical_shift_left_unit (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o
);

  reg  [31:0]            wide_result_reg;
  reg  [31:0]            prod_q;
  reg  [31:0]            multiplicand_reg;
  reg  [`ST_WIDTH-1:0]   status_q;
  reg  [15:0]            repeat_count;
  reg  [15:0]            opcode_q;

  wire                   req;
  wire                   wr;
  wire                   issue;
  wire [15:0]            opc;
  wire [15:0]            cnt_word;
  wire                   object_mode_bit;
  wire                   shift_a;
  wire [3:0]             shift_amount_field;

  // Byte-lane merge used by the accumulator, product, multiplicand and repeat-count registers
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer      i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // Request is acted on once, in the cycle before ack rises
  assign req   = cyc_i & stb_i & ~ack_o;
  assign wr    = req & we_i;
  // Opcode issue needs both low byte lanes so a half-written opcode never runs
  assign issue = wr & (adr_i == `OFS_OPCODE) & sel_i[0] & sel_i[1];
  assign opc   = dat_i[15:0];

  // Count source is the multiplicand's upper word
  assign cnt_word           = multiplicand_reg[31:16]; // [RULE19]
  assign object_mode_bit    = status_q[`ST_OBJECT_MODE_BIT];
  assign shift_a            = opc[4];
  assign shift_amount_field = opc[3:0];

  // Decode
  wire is_half_imm = (opc[15:5] == `OPC_HALF_IMM); // [RULE7]
  wire is_half_reg = (opc[15:1] == `OPC_HALF_REG); // [RULE11]
  wire is_acc_reg  = (opc == `OPC_ACC_REG); // [RULE21]
  wire is_wide_imm = (opc[15:4] == `OPC_WIDE_IMM);
  wire is_wide_reg = (opc == `OPC_WIDE_REG);
  // Wide forms are illegal outside object mode 1 and leave accumulator, product, carry, negative, zero and repeat count untouched
  wire ok_wide_imm = is_wide_imm & object_mode_bit; // [RULE14]
  wire ok_wide_reg = is_wide_reg & object_mode_bit; // [RULE18]
  wire is_half     = is_half_imm | is_half_reg;
  wire is_wide     = ok_wide_imm | ok_wide_reg;
  wire is_shift    = is_half | is_acc_reg | is_wide;
  wire half_sel    = is_half_imm ? shift_a : opc[0];

  // Amounts: immediate field encodes 1..16, register counts are masked
  wire [4:0] imm_amt  = {1'b0, shift_amount_field} + 5'h01;
  wire [4:0] cnt4     = {1'b0, cnt_word[`CNT4_BITS-1:0]}; // [RULE1] [RULE11]
  wire [6:0] cnt6     = {1'b0, cnt_word[`CNT6_BITS-1:0]}; // [RULE20]
  wire [4:0] half_amt = is_half_imm ? imm_amt : cnt4;
  wire [6:0] wide_amt = ok_wide_imm ? {2'b00, imm_amt} : cnt6;

  // Shifts carry one extra bit on top; it holds the last bit out, and stays zero
  // when the count is zero, which gives the clear-on-zero carry for free
  wire [15:0] half_in  = half_sel ? wide_result_reg[31:16] : wide_result_reg[15:0];
  wire [16:0] half_ext = {1'b0, half_in} << half_amt; // [RULE8]
  wire [32:0] acc_ext  = {1'b0, wide_result_reg} << cnt4; // [RULE2]
  wire [64:0] wide_ext = {1'b0, wide_result_reg, prod_q} << wide_amt; // [RULE14]

  // Flag candidates
  wire half_c = half_ext[16]; // [RULE8] [RULE12]
  wire half_n = half_ext[15]; // [RULE9] [RULE13]
  wire half_z = (half_ext[15:0] == 16'h0000); // [RULE10] [RULE13]
  wire acc_c  = acc_ext[32]; // [RULE3]
  wire acc_n  = acc_ext[31]; // [RULE5]
  wire acc_z  = (acc_ext[31:0] == 32'h00000000); // [RULE4]
  wire wide_c = wide_ext[64]; // [RULE17] [RULE20]
  wire wide_n = wide_ext[63]; // [RULE15]
  wire wide_z = (wide_ext[63:0] == 64'h0000000000000000); // [RULE16]

  reg [31:0] acc_d;
  reg [31:0] prod_d;
  reg        c_d;
  reg        n_d;
  reg        z_d;

  // Repeat count keeps only the low half of the merged bus word
  wire [31:0] rpt_merged = merge({16'h0000, repeat_count}, dat_i, sel_i);

  always @* begin
    acc_d  = wide_result_reg; // [RULE22]
    prod_d = prod_q;
    c_d    = status_q[`ST_CARRY];
    n_d    = status_q[`ST_NEG];
    z_d    = status_q[`ST_ZERO];
    if (is_half) begin
      if (half_sel) begin
        acc_d[31:16] = half_ext[15:0];
      end else begin
        acc_d[15:0] = half_ext[15:0];
      end
      c_d = half_c;
      n_d = half_n;
      z_d = half_z;
    end else if (is_acc_reg) begin
      acc_d = acc_ext[31:0];
      c_d   = acc_c;
      n_d   = acc_n;
      z_d   = acc_z;
    end else if (is_wide) begin
      acc_d  = wide_ext[63:32];
      prod_d = wide_ext[31:0];
      c_d    = wide_c;
      n_d    = wide_n;
      z_d    = wide_z;
    end
  end

  // Register file and execution; a shift completes in the single issue cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      wide_result_reg  <= `RST_ACC;
      prod_q           <= `RST_PROD;
      multiplicand_reg <= `RST_MCAND;
      status_q         <= `RST_STATUS;
      repeat_count     <= `RST_RPT;
      opcode_q         <= `RST_OPCODE;
    end else if (issue) begin
      opcode_q <= opc;
      if (is_shift) begin
        wide_result_reg          <= acc_d;
        prod_q                   <= prod_d;
        status_q[`ST_CARRY]      <= c_d;
        status_q[`ST_NEG]        <= n_d;
        status_q[`ST_ZERO]       <= z_d;
        status_q[`ST_ILLEGAL]    <= 1'b0;
        status_q[`ST_DONE]       <= 1'b1;
        // A pending repeat prefix is dropped; the shift ran exactly once
        repeat_count             <= 16'h0000; // [RULE6]
      end else begin
        // Unknown opcode or wide form outside object mode: flag only
        status_q[`ST_ILLEGAL]    <= 1'b1;
        status_q[`ST_DONE]       <= 1'b0;
      end
    end else if (wr) begin
      case (adr_i)
        `OFS_ACC: begin
          wide_result_reg <= merge(wide_result_reg, dat_i, sel_i);
        end
        `OFS_PROD: begin
          prod_q <= merge(prod_q, dat_i, sel_i);
        end
        `OFS_MCAND: begin
          multiplicand_reg <= merge(multiplicand_reg, dat_i, sel_i);
        end
        `OFS_STATUS: begin
          if (sel_i[0]) begin
            status_q <= dat_i[`ST_WIDTH-1:0];
          end
        end
        `OFS_RPT: begin
          repeat_count <= rpt_merged[15:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Bus answer: one wait state, unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      if (req & ~we_i) begin
        case (adr_i)
          `OFS_ACC:    dat_o <= wide_result_reg;
          `OFS_PROD:   dat_o <= prod_q;
          `OFS_MCAND:  dat_o <= multiplicand_reg;
          `OFS_STATUS: dat_o <= {{(32-`ST_WIDTH){1'b0}}, status_q};
          `OFS_RPT:    dat_o <= {16'h0000, repeat_count};
          `OFS_OPCODE: dat_o <= {16'h0000, opcode_q};
          default:     dat_o <= 32'h00000000;
        endcase
      end else begin
        dat_o <= 32'h00000000;
      end
    end
  end

endmodule // logical_shift_left_unit

// file: dv/cpu_bus_model.sv
// Wishbone master standing in for the decoder and register file
`timescale 1ns/1ps
module cpu_bus_model (
  // Clock
  input  wire         clk_i,
  // Wishbone master
  output logic        cyc_o,
  output logic        stb_o,
  output logic        we_o,
  output logic [7:0]  adr_o,
  output logic [3:0]  sel_o,
  output logic [31:0] dat_o,
  input  wire  [31:0] dat_i,
  input  wire         ack_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'hF;
    dat_o = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    // Released data is inverted so a stale value never looks valid
    dat_o <= ~d;
  endtask
endmodule // cpu_bus_model

// file: dv/lsl_unit_asserts.sv
// Port-level checks of the left-shift unit
`timescale 1ns/1ps
`include "lsl_unit_regs.vh"
module lsl_unit_asserts (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Wishbone slave
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire [3:0]  sel_i,
  input wire [31:0] dat_i,
  input wire [31:0] dat_o,
  input wire        ack_o
);
  wire req = cyc_i && stb_i && !ack_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (req |=> ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held too long");
  AST_ACK_CAUSE: assert property (!req |=> !ack_o)
    else $error("ack without request");
  AST_DAT_QUIET: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data outside ack");
  AST_RESET_QUIET: assert property (disable iff (1'b0) rst_i |=> !ack_o && dat_o == 32'h0)
    else $error("bus active in reset");
  AST_UNMAPPED: assert property (req && !we_i && adr_i > `OFS_OPCODE |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
  AST_RPT_WIDTH: assert property (req && !we_i && adr_i == `OFS_RPT |=> dat_o[31:16] == 16'h0)
    else $error("repeat count wider than 16 bits");
  AST_RPT_CLEAR: assert property (req && we_i && adr_i == `OFS_OPCODE && sel_i == 4'hF &&
    dat_i[15:0] == `OPC_ACC_REG ##1 ack_o ##1 !cyc_i ##1 (req && !we_i && adr_i == `OFS_RPT)
    |=> dat_o[15:0] == 16'h0000) else $error("repeat count kept after shift");
endmodule // lsl_unit_asserts
bind logical_shift_left_unit lsl_unit_asserts lsl_unit_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o));

// file: dv/logical_shift_left_unit_tb_top.sv
// Random and corner shift tests of the left-shift unit
`timescale 1ns/1ps
`include "lsl_unit_regs.vh"
module logical_shift_left_unit_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  wire         cyc, stb, we, ack;
  wire  [7:0]  adr;
  wire  [3:0]  sel;
  wire  [31:0] wdat, rdat;
  logic [31:0] q, seed = 32'h39FDF3C3;
  int          miscompares = 0;
  int          tests_run = 0;
  always #12.5 clk_i = ~clk_i;
  logical_shift_left_unit logical_shift_left_unit_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack));
  cpu_bus_model cpu_bus_model_i (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Returns carry over the masked result; a zero count leaves carry clear
  function automatic logic [64:0] shl(input logic [63:0] v, input int w, input int n);
    logic [64:0] r;
    r = {1'b0, v} << n;
    return {(n > 0) && r[w], r[63:0] & ~(64'hFFFFFFFFFFFFFFFF << w)};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    cpu_bus_model_i.xfer(w, a, d, q);
  endtask
  task automatic results();
    $display("comparisons=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #250000;
    miscompares++;
    results();
  end
  initial begin
    logic [31:0] a, p, t, st, f, repeat_prefix, ea, ep;
    logic [63:0] v;
    logic [64:0] r;
    logic [15:0] op;
    logic [4:0]  est;
    logic        bad;
    int          k, w, n;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 60; i++) begin
      a = rnd();
      p = rnd();
      t = rnd();
      st = rnd();
      f = rnd();
      repeat_prefix = rnd();
      k = rnd() % 5;
      // Corners: every opcode, first with a zero register count, then with immediate amount 16
      if (i < 10) begin
        k = i % 5;
        st[3] = 1'b1;
        if (i < 5) t[21:16] = 6'h00;
        else f[3:0] = 4'hF;
      end
      v = {32'h0, a};
      case (k)
        0: begin op = `OPC_ACC_REG; w = 32; n = t[19:16]; end
        1: begin op = {`OPC_HALF_IMM, f[4], f[3:0]}; w = 16; n = f[3:0] + 1; end
        2: begin op = {`OPC_HALF_REG, f[4]}; w = 16; n = t[19:16]; end
        3: begin op = {`OPC_WIDE_IMM, f[3:0]}; v = {a, p}; w = 64; n = f[3:0] + 1; end
        default: begin op = `OPC_WIDE_REG; v = {a, p}; w = 64; n = t[21:16]; end
      endcase
      if (w == 16) v = {48'h0, f[4] ? a[31:16] : a[15:0]};
      bus(1'b1, `OFS_ACC, a);
      bus(1'b1, `OFS_PROD, p);
      bus(1'b1, `OFS_MCAND, t);
      bus(1'b1, `OFS_STATUS, {28'h0, st[3:0]});
      bus(1'b1, `OFS_RPT, repeat_prefix);
      bus(1'b1, `OFS_OPCODE, {16'h0, op});
      r = shl(v, w, n);
      bad = (k > 2) && !st[3];
      est = bad ? {1'b1, st[3:0]} : {1'b0, st[3], r[63:0] == 64'h0, r[w-1], r[64]};
      ea = (w == 64) ? r[63:32] : (w == 32) ? r[31:0] :
           f[4] ? {r[15:0], a[15:0]} : {a[31:16], r[15:0]};
      ep = (w == 64) ? r[31:0] : p;
      if (bad) ea = a;
      if (bad) ep = p;
      bus(1'b0, `OFS_RPT, 32'h0);
      check(q, {16'h0, bad ? repeat_prefix[15:0] : 16'h0000});
      bus(1'b0, `OFS_ACC, 32'h0);
      check(q, ea);
      bus(1'b0, `OFS_PROD, 32'h0);
      check(q, ep);
      bus(1'b0, `OFS_STATUS, 32'h0);
      check(q & {27'h0, bad, 4'hF}, {27'h0, est});
      bus(1'b0, `OFS_OPCODE, 32'h0);
      check(q, {16'h0, op});
    end
    bus(1'b0, 8'h80, 32'h0);
    check(q, 32'h00000000);
    results();
  end
endmodule // logical_shift_left_unit_tb_top
